// *** flg_regs.sv ***
// fault latch, general pin and attention registers behind an i2c word slave
`timescale 1ns/1ps
module flg_regs #(
	parameter logic [6:0] DEV_ADDR = 7'h5C,
	parameter logic TRACK_VARIANT = 1'b0
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic [13:0] live_flags,
	input wire logic [7:0] dac_code_ch0,
	input wire logic [7:0] dac_code_ch1,
	input wire logic servo_en_ch0,
	input wire logic servo_en_ch1,
	input wire logic continuous_servo_ch0,
	input wire logic continuous_servo_ch1,
	input wire logic monitor_select_ch0,
	input wire logic monitor_select_ch1,
	output logic reservo_req_ch0,
	output logic reservo_req_ch1,
	output logic test_result_write,
	output logic track_start,
	input wire logic tracking_pending,
	output logic ext_wr,
	output logic [7:0] ext_cmd,
	output logic [15:0] ext_wdata,
	input wire logic [15:0] ext_rdata,
	input wire logic gp0_in,
	output logic gp0_out,
	output logic gp0_oe_n,
	input wire logic gp1_in,
	output logic gp1_out,
	output logic gp1_oe_n,
	input wire logic alert_in,
	output logic alert_out,
	output logic alert_oe_n,
	input wire logic strap_in
);
	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_CMD, ST_WDAT, ST_RDAT} flg_bus_state_type;

	generate
		if (DEV_ADDR == flg_pkg::GLOBAL_ADDR || DEV_ADDR == flg_pkg::ARA_ADDR) begin : g_bad_addr
			$error("device address collides with a shared address");
		end
	endgenerate

	// ----------------------------------------------------------------
	// pin synchronisation and bus edges
	// ----------------------------------------------------------------
	logic [5:0] pins_raw;
	logic [5:0] pins_s;
	logic scl_s, sda_s, gp0_s, gp1_s, alert_s, strap_s;
	logic scl_prev_reg, sda_prev_reg;
	logic start_det, stop_det, scl_rise, scl_fall;

	assign pins_raw = {strap_in, alert_in, gp1_in, gp0_in, sda_in, scl_in};

	flg_sync #(.WIDTH(6)) u_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.ce(ce),
		.async_in(pins_raw),
		.sync_out(pins_s)
	);

	assign {strap_s, alert_s, gp1_s, gp0_s, sda_s, scl_s} = pins_s;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else if (ce) begin
			scl_prev_reg <= scl_s;
			sda_prev_reg <= sda_s;
		end
	end

	assign start_det = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
	assign stop_det = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;
	assign scl_rise = scl_s && !scl_prev_reg;
	assign scl_fall = !scl_s && scl_prev_reg;

	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	logic [15:0] en_reg, en_next;
	logic [13:0] latched_reg, latched_next;
	logic [1:0] cfg0_reg, cfg1_reg;
	logic gp0_data_reg, gp1_data_reg, alert_mask_reg, test_wen_reg;
	logic [1:0] strap_wait_reg;
	logic supply_ok, dac_code_error, gp0_val, gp1_val;
	logic [15:0] pin_word, rd_word;
	logic wr_pulse_reg, rd_clr_reg, track_pulse_reg;
	logic [15:0] wr_word_reg;
	logic [7:0] cmd_reg;
	logic local_cmd;

	// pin value by mode; input mode returns the pin level
	function automatic logic gp_value(input logic [1:0] mode, input logic status, input logic data,
			input logic pin);
		unique case (mode)
			flg_pkg::GP_MODE_STATUS: gp_value = status;
			flg_pkg::GP_MODE_STATUS_INV: gp_value = !status;
			flg_pkg::GP_MODE_OUTPUT: gp_value = data;
			flg_pkg::GP_MODE_INPUT: gp_value = pin;
		endcase
	endfunction : gp_value

	assign supply_ok = !(|(live_flags & flg_pkg::SUPPLY_FLAG_MASK));
	assign dac_code_error = dac_code_ch0 == flg_pkg::DAC_CODE_LOW || dac_code_ch0 == flg_pkg::DAC_CODE_HIGH
		|| dac_code_ch1 == flg_pkg::DAC_CODE_LOW || dac_code_ch1 == flg_pkg::DAC_CODE_HIGH;
	assign gp0_val = gp_value(cfg0_reg, supply_ok, gp0_data_reg, gp0_s);
	assign gp1_val = gp_value(cfg1_reg, dac_code_error, gp1_data_reg, gp1_s);

	// ----------------------------------------------------------------
	// fault latch
	// ----------------------------------------------------------------
	assign en_next = (wr_pulse_reg && cmd_reg == flg_pkg::CMD_LATCH_EN) ? wr_word_reg : en_reg;
	// live flags win over the clearing read
	assign latched_next = ((latched_reg & ~{flg_pkg::FLAG_W{rd_clr_reg}}) | live_flags)
		& en_next[flg_pkg::FLAG_W-1:0];

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			en_reg <= flg_pkg::LATCH_EN_RESET;
			latched_reg <= '0;
		end else if (ce) begin
			en_reg <= en_next;
			latched_reg <= latched_next;
		end
	end

	// re-servo request on the rising edge of a qualified supply trip
	logic reservo_cond0, reservo_cond1, reservo_prev0_reg, reservo_prev1_reg;
	assign reservo_cond0 = en_reg[flg_pkg::EN_RESERVO0] && servo_en_ch0 && !continuous_servo_ch0
		&& monitor_select_ch0 && (live_flags[flg_pkg::FL_CH0_OV] || live_flags[flg_pkg::FL_CH0_UV]);
	assign reservo_cond1 = en_reg[flg_pkg::EN_RESERVO1] && servo_en_ch1 && !continuous_servo_ch1
		&& monitor_select_ch1 && (live_flags[flg_pkg::FL_CH1_OV] || live_flags[flg_pkg::FL_CH1_UV]);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reservo_prev0_reg <= 1'b0;
			reservo_prev1_reg <= 1'b0;
			reservo_req_ch0 <= 1'b0;
			reservo_req_ch1 <= 1'b0;
		end else if (ce) begin
			reservo_prev0_reg <= reservo_cond0;
			reservo_prev1_reg <= reservo_cond1;
			reservo_req_ch0 <= reservo_cond0 && !reservo_prev0_reg;
			reservo_req_ch1 <= reservo_cond1 && !reservo_prev1_reg;
		end
	end

	// ----------------------------------------------------------------
	// pin control register and pins
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cfg0_reg <= flg_pkg::GP_MODE_OUTPUT;
			cfg1_reg <= flg_pkg::GP_MODE_OUTPUT;
			gp0_data_reg <= flg_pkg::GP_DATA_RESET;
			gp1_data_reg <= flg_pkg::GP_DATA_RESET;
			alert_mask_reg <= flg_pkg::ALERT_MASK_RESET;
			test_wen_reg <= 1'b0;
			track_pulse_reg <= 1'b0;
			strap_wait_reg <= '0;
		end else if (ce) begin
			track_pulse_reg <= 1'b0;
			if (strap_wait_reg != flg_pkg::STRAP_WAIT) begin
				strap_wait_reg <= strap_wait_reg + 2'h1;
			end
			if (strap_wait_reg == flg_pkg::STRAP_WAIT - 2'h1 && strap_s) begin
				gp0_data_reg <= 1'b0;
				gp1_data_reg <= 1'b0;
			end else if (wr_pulse_reg && cmd_reg == flg_pkg::CMD_PIN_CTRL) begin
				cfg0_reg <= wr_word_reg[flg_pkg::PC_CFG0_LSB +: 2];
				cfg1_reg <= wr_word_reg[flg_pkg::PC_CFG1_LSB +: 2];
				gp0_data_reg <= wr_word_reg[flg_pkg::PC_GP0];
				gp1_data_reg <= wr_word_reg[flg_pkg::PC_GP1];
				alert_mask_reg <= wr_word_reg[flg_pkg::PC_ALERT_MASK];
				test_wen_reg <= wr_word_reg[flg_pkg::PC_TEST_WEN];
				track_pulse_reg <= TRACK_VARIANT && wr_word_reg[flg_pkg::PC_TRACK];
			end
		end
	end

	// open-drain drivers pull low when the value is zero
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			gp0_oe_n <= 1'b1;
			gp1_oe_n <= 1'b1;
			alert_oe_n <= 1'b1;
		end else if (ce) begin
			gp0_oe_n <= cfg0_reg == flg_pkg::GP_MODE_INPUT || gp0_val;
			gp1_oe_n <= cfg1_reg == flg_pkg::GP_MODE_INPUT || gp1_val;
			alert_oe_n <= alert_mask_reg || !(|latched_reg);
		end
	end

	assign gp0_out = 1'b0;
	assign gp1_out = 1'b0;
	assign alert_out = 1'b0;
	assign sda_out = 1'b0;
	assign test_result_write = test_wen_reg;
	assign track_start = ce && track_pulse_reg;
	assign local_cmd = cmd_reg == flg_pkg::CMD_LATCH_EN || cmd_reg == flg_pkg::CMD_PIN_CTRL;
	assign ext_wr = ce && wr_pulse_reg && !local_cmd;
	assign ext_cmd = cmd_reg;
	assign ext_wdata = wr_word_reg;

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	always_comb begin
		pin_word = 16'h0000;
		pin_word[flg_pkg::PC_CFG0_LSB +: 2] = cfg0_reg;
		pin_word[flg_pkg::PC_CFG1_LSB +: 2] = cfg1_reg;
		pin_word[flg_pkg::PC_GP0] = gp0_val;
		pin_word[flg_pkg::PC_GP1] = gp1_val;
		pin_word[flg_pkg::PC_ALERT_PIN] = alert_s;
		pin_word[flg_pkg::PC_ALERT_MASK] = alert_mask_reg;
		pin_word[flg_pkg::PC_TEST_WEN] = test_wen_reg;
		pin_word[flg_pkg::PC_STRAP] = strap_s;
		pin_word[flg_pkg::PC_TRACK] = TRACK_VARIANT && tracking_pending;
	end

	always_comb begin
		case (cmd_reg)
			flg_pkg::CMD_LIVE: rd_word = {2'b00, live_flags};
			flg_pkg::CMD_LATCH_EN: rd_word = en_reg;
			flg_pkg::CMD_SUMMARY: rd_word = {15'h0000, |latched_reg};
			flg_pkg::CMD_LATCHED: rd_word = {2'b00, latched_reg};
			flg_pkg::CMD_PIN_CTRL: rd_word = pin_word;
			default: rd_word = ext_rdata;
		endcase
	end

	// ----------------------------------------------------------------
	// i2c word slave
	// ----------------------------------------------------------------
	flg_bus_state_type st_reg, next_st_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] sh_reg, wlo_reg;
	logic [15:0] tx_word_reg;
	logic [7:0] tx_byte;
	logic [1:0] byte_idx_reg;
	logic in_ack_reg, sda_low_reg, cmd_ok_reg, rd_hi_reg, decide;
	logic [6:0] rx_addr;

	assign tx_byte = rd_hi_reg ? tx_word_reg[15:8] : tx_word_reg[7:0];
	assign rx_addr = sh_reg[7:1];
	assign decide = scl_fall && !in_ack_reg && bit_cnt_reg == flg_pkg::BYTE_BITS && st_reg != ST_RDAT
		&& st_reg != ST_IDLE;
	assign sda_oe_n = !sda_low_reg;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_reg <= ST_IDLE;
			next_st_reg <= ST_IDLE;
			bit_cnt_reg <= '0;
			sh_reg <= '0;
			wlo_reg <= '0;
			wr_word_reg <= '0;
			tx_word_reg <= '0;
			cmd_reg <= flg_pkg::CMD_LIVE;
			byte_idx_reg <= '0;
			in_ack_reg <= 1'b0;
			sda_low_reg <= 1'b0;
			cmd_ok_reg <= 1'b0;
			rd_hi_reg <= 1'b0;
			wr_pulse_reg <= 1'b0;
			rd_clr_reg <= 1'b0;
		end else if (ce) begin
			wr_pulse_reg <= 1'b0;
			rd_clr_reg <= 1'b0;
			if (start_det) begin
				st_reg <= ST_ADDR;
				bit_cnt_reg <= '0;
				in_ack_reg <= 1'b0;
				sda_low_reg <= 1'b0;
			end else if (stop_det) begin
				st_reg <= ST_IDLE;
				sda_low_reg <= 1'b0;
				cmd_ok_reg <= 1'b0;
			end else if (scl_rise) begin
				if (st_reg == ST_RDAT) begin
					if (bit_cnt_reg == flg_pkg::BYTE_BITS) begin
						if (sda_s) begin
							st_reg <= ST_IDLE;
						end else begin
							bit_cnt_reg <= '0;
							rd_hi_reg <= 1'b1;
						end
					end else begin
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end
				end else if (st_reg != ST_IDLE && !in_ack_reg) begin
					sh_reg <= {sh_reg[6:0], sda_s};
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
				end
			end else if (scl_fall) begin
				if (in_ack_reg) begin
					in_ack_reg <= 1'b0;
					bit_cnt_reg <= '0;
					st_reg <= next_st_reg;
					rd_hi_reg <= 1'b0;
					sda_low_reg <= next_st_reg == ST_RDAT && !tx_word_reg[7];
				end else if (st_reg == ST_RDAT) begin
					sda_low_reg <= bit_cnt_reg < flg_pkg::BYTE_BITS
						&& !tx_byte[3'(flg_pkg::BYTE_BITS - 4'h1 - bit_cnt_reg)];
				end else if (decide) begin
					in_ack_reg <= 1'b1;
					sda_low_reg <= 1'b0;
					next_st_reg <= ST_IDLE;
					unique case (st_reg)
						ST_ADDR: begin
							if (rx_addr == flg_pkg::ARA_ADDR && sh_reg[0] && !alert_oe_n) begin
								sda_low_reg <= 1'b1;
								next_st_reg <= ST_RDAT;
								tx_word_reg <= {8'h00, DEV_ADDR, 1'b0};
							end else if (rx_addr == DEV_ADDR || rx_addr == flg_pkg::GLOBAL_ADDR) begin
								if (!sh_reg[0]) begin
									sda_low_reg <= 1'b1;
									next_st_reg <= ST_CMD;
								end else if (cmd_ok_reg) begin
									sda_low_reg <= 1'b1;
									next_st_reg <= ST_RDAT;
									tx_word_reg <= rd_word;
									rd_clr_reg <= cmd_reg == flg_pkg::CMD_LATCHED;
								end
							end
						end
						ST_CMD: begin
							// unknown and, on the base variant, tracking codes are refused
							if (flg_pkg::flg_cmd_known(sh_reg, TRACK_VARIANT)) begin
								sda_low_reg <= 1'b1;
								next_st_reg <= ST_WDAT;
								cmd_reg <= sh_reg;
								cmd_ok_reg <= 1'b1;
								byte_idx_reg <= '0;
							end else begin
								cmd_ok_reg <= 1'b0;
							end
						end
						ST_WDAT: begin
							if (byte_idx_reg == 2'h0) begin
								sda_low_reg <= 1'b1;
								next_st_reg <= ST_WDAT;
								wlo_reg <= sh_reg;
								byte_idx_reg <= 2'h1;
							end else if (byte_idx_reg == 2'h1) begin
								sda_low_reg <= 1'b1;
								wr_word_reg <= {sh_reg, wlo_reg};
								wr_pulse_reg <= 1'b1;
								byte_idx_reg <= 2'h2;
							end
						end
						default: begin
						end
					endcase
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	property p_live_word;
		ce && decide && st_reg == ST_ADDR && sh_reg[0] && cmd_ok_reg && cmd_reg == flg_pkg::CMD_LIVE
			&& rx_addr == DEV_ADDR |=> tx_word_reg == {2'b00, $past(live_flags)};
	endproperty
	a_live_word: assert property (p_live_word) else $error("live status word wrong");

	property p_disabled_zero;
		(latched_reg & ~en_reg[flg_pkg::FLAG_W-1:0]) == 14'h0000;
	endproperty
	a_disabled_zero: assert property (p_disabled_zero) else $error("disabled latch bit set");

	property p_latch_set;
		ce && !wr_pulse_reg |=> (latched_reg & $past(live_flags & en_reg[flg_pkg::FLAG_W-1:0]))
			== $past(live_flags & en_reg[flg_pkg::FLAG_W-1:0]);
	endproperty
	a_latch_set: assert property (p_latch_set) else $error("enabled flag not latched");

	property p_summary;
		ce && decide && st_reg == ST_ADDR && sh_reg[0] && cmd_ok_reg && cmd_reg == flg_pkg::CMD_SUMMARY
			&& rx_addr == DEV_ADDR |=> tx_word_reg == {15'h0000, |$past(latched_reg)} && !rd_clr_reg;
	endproperty
	a_summary: assert property (p_summary) else $error("summary word wrong");

	property p_clear_on_read;
		ce && rd_clr_reg && !wr_pulse_reg |=> latched_reg == ($past(live_flags) & en_reg[flg_pkg::FLAG_W-1:0]);
	endproperty
	a_clear_on_read: assert property (p_clear_on_read) else $error("read did not clear latch");

	property p_enable_clear;
		ce && wr_pulse_reg && cmd_reg == flg_pkg::CMD_LATCH_EN |=>
			(latched_reg & ~$past(wr_word_reg[flg_pkg::FLAG_W-1:0])) == 14'h0000;
	endproperty
	a_enable_clear: assert property (p_enable_clear) else $error("enable clear missed");

	property p_alert;
		ce && !alert_mask_reg && |latched_reg |=> !alert_oe_n ##0 (alert_mask_reg || !alert_oe_n);
	endproperty
	a_alert: assert property (p_alert) else $error("attention pin not driven");

	property p_alert_masked;
		ce && alert_mask_reg ##1 ce && alert_mask_reg |-> alert_oe_n;
	endproperty
	a_alert_masked: assert property (p_alert_masked) else $error("masked attention pin driven");

	property p_refuse_cmd;
		ce && decide && st_reg == ST_CMD && !flg_pkg::flg_cmd_known(sh_reg, TRACK_VARIANT) |=> !sda_low_reg;
	endproperty
	a_refuse_cmd: assert property (p_refuse_cmd) else $error("reserved command acknowledged");

	property p_gp0_status;
		ce && cfg0_reg == flg_pkg::GP_MODE_STATUS ##1 ce && cfg0_reg == flg_pkg::GP_MODE_STATUS
			|-> gp0_oe_n == !(|($past(live_flags) & flg_pkg::SUPPLY_FLAG_MASK));
	endproperty
	a_gp0_status: assert property (p_gp0_status) else $error("pin 0 supply ok wrong");

endmodule : flg_regs

// *** flg_pkg.sv ***
// constants shared by the fault latch and general pin register logic
// Operation
// - live status shows fourteen flags, top zero
// - disabled latch bit always reads zero
// - enabled live flag sets its latched bit
// - enable bits 14/15 request re-servo on trip
// - summary bit is OR of latched bits
// - latched bits set and held while enabled
// - clearing enable clears latched bit at once
// - reading latched status clears latched bits whose live flag is gone
// - mode 00 pin 0 carries supply ok
// - mode 01 pin 0 carries inverted supply ok
// - mode 10 pin 0 open-drain follows data
// - mode 11 pin 0 is input, readable
// - pin 1 carries DAC code error or inverse
// - pin 1 open-drain output or readable input
// - strap high at reset clears pin data
// - status bits mirror attention and strap pins
// - mask bit blocks attention, else latched drives
// - test bit lets host write result registers
// - tracking start bit, pending readback, variant only
// - base variant refuses tracking-only command codes
// - decode temperature and channel 1 servo codes
// - map the five block registers to codes
// - word read, word write and alert response
package flg_pkg;

	// ----------------------------------------------------------------
	// command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_LIVE = 8'h00;
	localparam logic [7:0] CMD_LATCH_EN = 8'h08;
	localparam logic [7:0] CMD_SUMMARY = 8'h10;
	localparam logic [7:0] CMD_LATCHED = 8'h11;
	localparam logic [7:0] CMD_PIN_CTRL = 8'h17;
	localparam logic [7:0] CMD_SYNC = 8'h1F;
	localparam logic [7:0] CMD_TRK_FINAL0 = 8'h45;
	localparam logic [7:0] CMD_TRK_DELAY0 = 8'h46;
	localparam logic [7:0] CMD_SERVO1 = 8'h53;
	localparam logic [7:0] CMD_TRK_FINAL1 = 8'h55;
	localparam logic [7:0] CMD_TRK_DELAY1 = 8'h56;
	localparam logic [7:0] CMD_TEMP = 8'h68;

	// ----------------------------------------------------------------
	// bus addresses and bit counts
	// ----------------------------------------------------------------
	localparam logic [6:0] GLOBAL_ADDR = 7'h5B;
	localparam logic [6:0] ARA_ADDR = 7'h0C;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [1:0] STRAP_WAIT = 2'h3;

	// ----------------------------------------------------------------
	// flag layout
	// ----------------------------------------------------------------
	localparam int FLAG_W = 14;
	localparam logic [13:0] SUPPLY_FLAG_MASK = 14'h3F7B;
	localparam int EN_RESERVO0 = 14;
	localparam int EN_RESERVO1 = 15;
	localparam int FL_CH0_OV = 0;
	localparam int FL_CH0_UV = 1;
	localparam int FL_CH1_OV = 5;
	localparam int FL_CH1_UV = 6;
	localparam logic [7:0] DAC_CODE_LOW = 8'h00;
	localparam logic [7:0] DAC_CODE_HIGH = 8'hFF;

	// ----------------------------------------------------------------
	// pin control word layout and reset values
	// ----------------------------------------------------------------
	localparam int PC_CFG0_LSB = 0;
	localparam int PC_CFG1_LSB = 2;
	localparam int PC_GP0 = 4;
	localparam int PC_GP1 = 5;
	localparam int PC_ALERT_PIN = 6;
	localparam int PC_ALERT_MASK = 7;
	localparam int PC_TEST_WEN = 8;
	localparam int PC_STRAP = 9;
	localparam int PC_TRACK = 10;
	localparam logic [1:0] GP_MODE_STATUS = 2'h0;
	localparam logic [1:0] GP_MODE_STATUS_INV = 2'h1;
	localparam logic [1:0] GP_MODE_OUTPUT = 2'h2;
	localparam logic [1:0] GP_MODE_INPUT = 2'h3;
	localparam logic [15:0] LATCH_EN_RESET = 16'h0000;
	localparam logic GP_DATA_RESET = 1'b1;
	localparam logic ALERT_MASK_RESET = 1'b1;

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------
	function automatic logic flg_cmd_known(input logic [7:0] cmd, input logic track);
		case (cmd)
			8'h00, 8'h08, 8'h10, 8'h11, 8'h17, 8'h18, 8'h28, 8'h29, 8'h2A, 8'h38, 8'h39, 8'h3A,
			8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h48, 8'h49, 8'h4A, 8'h50, 8'h51, 8'h52,
			8'h53, 8'h54, 8'h58, 8'h59, 8'h5A, 8'h68: flg_cmd_known = 1'b1;
			8'h1F, 8'h45, 8'h46, 8'h55, 8'h56: flg_cmd_known = track;
			default: flg_cmd_known = 1'b0;
		endcase
	endfunction : flg_cmd_known

endpackage : flg_pkg

// *** flg_sync.sv ***
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module flg_sync #(
	parameter int WIDTH = 6
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage_reg;

	generate
		if (WIDTH < 1) begin : g_bad_width
			$error("flg_sync width must be at least one");
		end
	endgenerate

	// first stage feeds only the second
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			// released pin level, so no false edge follows reset
			stage_reg <= '1;
			sync_out <= '1;
		end else if (ce) begin
			stage_reg <= async_in;
			sync_out <= stage_reg;
		end
	end
endmodule : flg_sync

// *** flg_host.sv ***
// i2c word master standing in for the bus host
`timescale 1ns/1ps
module flg_host #(
	parameter logic [6:0] ADDR = 7'h5C
) (
	input wire logic ref_clk,
	input wire logic sda,
	output logic scl = 1'b1,
	output logic sda_low = 1'b0
);
	task automatic hold(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : hold
	task automatic bit_io(input logic b, output logic r);
		sda_low = ~b;
		hold(6);
		scl = 1'b1;
		hold(6);
		r = sda;
		scl = 1'b0;
		hold(1);
	endtask : bit_io
	task automatic start;
		sda_low = 1'b0;
		hold(6);
		scl = 1'b1;
		hold(6);
		sda_low = 1'b1;
		hold(6);
		scl = 1'b0;
		hold(2);
	endtask : start
	task automatic stop;
		sda_low = 1'b1;
		hold(6);
		scl = 1'b1;
		hold(6);
		sda_low = 1'b0;
		hold(6);
	endtask : stop
	task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q, output logic ok);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
		bit_io(last, r);
		ok = ~r;
	endtask : xfer
	task automatic wr_word(input logic [7:0] cmd, input logic [15:0] w, output logic ok);
		logic [7:0] q;
		logic [3:0] a;
		start();
		xfer({ADDR, 1'b0}, 1'b1, q, a[0]);
		xfer(cmd, 1'b1, q, a[1]);
		xfer(w[7:0], 1'b1, q, a[2]);
		xfer(w[15:8], 1'b1, q, a[3]);
		stop();
		ok = &a;
	endtask : wr_word
	task automatic rd_word(input logic [7:0] cmd, output logic [15:0] w);
		logic [7:0] q;
		logic a;
		start();
		xfer({ADDR, 1'b0}, 1'b1, q, a);
		xfer(cmd, 1'b1, q, a);
		start();
		xfer({ADDR, 1'b1}, 1'b1, q, a);
		xfer(8'hFF, 1'b0, w[7:0], a);
		xfer(8'hFF, 1'b1, w[15:8], a);
		stop();
	endtask : rd_word
	task automatic ara(output logic [7:0] q, output logic ok);
		logic [7:0] d;
		logic a;
		start();
		xfer({flg_pkg::ARA_ADDR, 1'b1}, 1'b1, d, ok);
		xfer(8'hFF, 1'b1, q, a);
		stop();
	endtask : ara
endmodule : flg_host

// *** tb_flg_regs.sv ***
// self-checking bench for the fault latch and general pin registers
`timescale 1ns/1ps
module tb_flg_regs;
	logic ref_clk, rst = 1'b1, gp0_ext = 1'b1, gp1_ext = 1'b1, ok, scl, sda_low, sok, derr, mask_m, v0, v1;
	logic sda_oe_n, alert_oe_n, gp0_oe_n, gp1_oe_n, ext_wr, trw;
	logic ce = 1'b1, strap = 1'b0;
	logic [1:0] rq;
	logic [7:0] q8;
	logic [31:0] lf = 32'hCA213814;
	logic [13:0] flags = '0, lat_m;
	logic [15:0] en, rd, pc, ext_wdata, rdata = '0;
	logic [7:0] dac0 = 8'h10, dac1 = 8'h10, ext_cmd;
	logic [5:0] srv = '0;
	logic [7:0] bad [6] = '{8'h1F, 8'h45, 8'h46, 8'h55, 8'h56, 8'h77};
	int miscompares, checks_done, cyc, wr_cnt, rq0, rq1, n0, n1;
	wire logic sda = ~sda_low & sda_oe_n;
	flg_regs dut_u (.ref_clk(ref_clk), .rst(rst), .ce(ce), .scl_in(scl), .sda_in(sda), .sda_out(),
		.sda_oe_n(sda_oe_n), .live_flags(flags), .dac_code_ch0(dac0), .dac_code_ch1(dac1),
		.servo_en_ch0(srv[0]), .servo_en_ch1(srv[1]), .continuous_servo_ch0(srv[2]),
		.continuous_servo_ch1(srv[3]), .monitor_select_ch0(srv[4]), .monitor_select_ch1(srv[5]),
		.reservo_req_ch0(rq[0]), .reservo_req_ch1(rq[1]), .test_result_write(trw), .track_start(),
		.tracking_pending(1'b0), .ext_wr(ext_wr), .ext_cmd(ext_cmd), .ext_wdata(ext_wdata), .ext_rdata(rdata),
		.gp0_in(gp0_oe_n ? gp0_ext : 1'b0), .gp0_out(), .gp0_oe_n(gp0_oe_n), .gp1_in(gp1_oe_n ? gp1_ext : 1'b0),
		.gp1_out(), .gp1_oe_n(gp1_oe_n), .alert_in(alert_oe_n), .alert_out(), .alert_oe_n(alert_oe_n),
		.strap_in(strap));
	flg_host host_u (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_low(sda_low));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic summarize;
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : summarize
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (ext_wr === 1'b1) wr_cnt++;
		if (rq[0] === 1'b1) rq0++;
		if (rq[1] === 1'b1) rq1++;
		if (cyc == 90000) begin
			miscompares++;
			summarize();
		end
	end
	initial begin
		repeat (6) @(negedge ref_clk);
		rst = 1'b0;
		repeat (6) @(negedge ref_clk);
		host_u.rd_word(flg_pkg::CMD_PIN_CTRL, rd);
		check(rd, 16'h00FA);
		lat_m = '0;
		mask_m = 1'b1;
		for (int i = 0; i < 6; i++) begin
			lf = lfsr(lf);
			flags = lf[13:0];
			srv = lf[21:16];
			en = (i == 5) ? 16'h0000 : lf[31:16];
			if (i == 0) en = 16'h0000;
			if (i == 3) host_u.wr_word(flg_pkg::CMD_PIN_CTRL, 16'h003A, ok);
			if (i == 3) mask_m = 1'b0;
			host_u.wr_word(flg_pkg::CMD_LATCH_EN, en, ok);
			lat_m = (lat_m | flags) & en[13:0];
			host_u.rd_word(flg_pkg::CMD_LIVE, rd);
			check(rd, {2'b00, flags});
			host_u.rd_word(flg_pkg::CMD_LATCH_EN, rd);
			check(rd, en);
			host_u.rd_word(flg_pkg::CMD_SUMMARY, rd);
			check(rd, {15'h0000, |lat_m});
			check({15'h0000, alert_oe_n}, {15'h0000, mask_m | ~|lat_m});
			host_u.ara(q8, ok);
			check({7'h00, ok, q8}, (mask_m | ~|lat_m) ? 16'h00FF : {7'h00, 1'b1, 7'h5C, 1'b0});
			host_u.rd_word(flg_pkg::CMD_LATCHED, rd);
			check(rd, {2'b00, lat_m});
			lat_m = flags & en[13:0];
			if (i[0]) flags = '0;
			host_u.rd_word(flg_pkg::CMD_LATCHED, rd);
			check(rd, {2'b00, lat_m});
			lat_m = flags & en[13:0];
		end
		for (int m = 0; m < 4; m++) begin
			lf = lfsr(lf);
			flags = lf[13:0];
			dac0 = lf[14] ? 8'h00 : lf[23:16];
			dac1 = lf[15] ? 8'hFF : lf[31:24];
			gp0_ext = lf[16];
			gp1_ext = lf[17];
			sok = ~|(flags & flg_pkg::SUPPLY_FLAG_MASK);
			derr = dac0 == 8'h00 || dac0 == 8'hFF || dac1 == 8'h00 || dac1 == 8'hFF;
			v0 = m == 3 ? gp0_ext : m == 2 ? 1'b0 : sok ^ m[0];
			v1 = m == 3 ? gp1_ext : m == 2 ? 1'b0 : derr ^ m[0];
			pc = {7'h00, m[0], 1'b1, 3'b000, m[1:0], m[1:0]};
			host_u.wr_word(flg_pkg::CMD_PIN_CTRL, pc, ok);
			repeat (4) @(negedge ref_clk);
			check({14'h0000, gp1_oe_n, gp0_oe_n}, {14'h0000, v1 | m == 3, v0 | m == 3});
			check({15'h0000, trw}, {15'h0000, m[0]});
			host_u.rd_word(flg_pkg::CMD_PIN_CTRL, rd);
			check(rd & 16'h073F, {7'h00, m[0], 2'b00, v1, v0, m[1:0], m[1:0]});
		end
		lf = lfsr(lf);
		rdata = lf[15:0];
		host_u.rd_word(flg_pkg::CMD_TEMP, rd);
		check(rd, rdata);
		host_u.wr_word(flg_pkg::CMD_SERVO1, lf[31:16], ok);
		check({ok, ext_cmd, 7'h00}, {1'b1, flg_pkg::CMD_SERVO1, 7'h00});
		check(ext_wdata, lf[31:16]);
		foreach (bad[k]) begin
			host_u.wr_word(bad[k], 16'hFFFF, ok);
			check({15'h0000, ok}, 16'h0000);
		end
		check(wr_cnt[15:0], 16'h0001);
		flags = '0;
		srv = 6'h33;
		host_u.wr_word(flg_pkg::CMD_LATCH_EN, 16'hC000, ok);
		n0 = rq0;
		n1 = rq1;
		ce = 1'b0;
		flags = 14'h0041;
		repeat (4) @(negedge ref_clk);
		check(16'(rq0 - n0 + rq1 - n1), 16'h0000);
		ce = 1'b1;
		repeat (4) @(negedge ref_clk);
		check(16'(rq0 - n0), 16'h0001);
		check(16'(rq1 - n1), 16'h0001);
		strap = 1'b1;
		rst = 1'b1;
		repeat (2) @(negedge ref_clk);
		rst = 1'b0;
		repeat (6) @(negedge ref_clk);
		check({14'h0000, gp1_oe_n, gp0_oe_n}, 16'h0000);
		host_u.rd_word(flg_pkg::CMD_PIN_CTRL, rd);
		check(rd, 16'h02CA);
		summarize();
	end
endmodule : tb_flg_regs
